// ===== inc/rwa_pkg.sv
// constants and types of the receive word aligner
package rwa_pkg;

   // =====================================================================
   // data path widths
   localparam int W_MAX    = 10;
   localparam int W_MIN    = 8;
   localparam int PAT8_LEN = 16;
   localparam int PAT7_LEN = 7;
   localparam logic [3:0] BND_LAST10 = 4'h9;
   localparam logic [3:0] BND_LAST8  = 4'h7;

   // =====================================================================
   // register offsets (byte addresses)
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_PATTERN  = 8'h04;
   localparam logic [7:0] OFF_SYNC_CFG = 8'h08;
   localparam logic [7:0] OFF_RLV_CFG  = 8'h0c;
   localparam logic [7:0] OFF_STATUS   = 8'h10;

   // =====================================================================
   // field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_W10_BIT  = 2;
   localparam int CTRL_P7_BIT   = 3;
   localparam int SYNC_ACQ_LSB  = 0;
   localparam int SYNC_LOSE_LSB = 8;
   localparam int SYNC_GOOD_LSB = 16;
   localparam int RLV_IDX_LSB   = 0;
   localparam int ST_SYNC_BIT   = 0;
   localparam int ST_RLV_BIT    = 1;
   localparam int ST_BND_LSB    = 2;
   localparam int ST_STATE_LSB  = 6;
   localparam int ST_ERR_LSB    = 8;

   // =====================================================================
   // reset values
   localparam logic [1:0]  MODE_RST     = 2'h0;
   localparam logic        W10_RST      = 1'h1;
   localparam logic        P7_RST       = 1'h0;
   localparam logic [15:0] PATTERN_RST  = 16'h017c;
   localparam logic [7:0]  ACQ_RST      = 8'h03;
   localparam logic [5:0]  LOSE_RST     = 6'h03;
   localparam logic [7:0]  GOOD_RST     = 8'h03;
   localparam logic [4:0]  RLV_IDX_RST  = 5'h1f;

   // =====================================================================
   // counting constants
   localparam logic [7:0] RLV_STEP8   = 8'h04;
   localparam logic [7:0] RLV_STEP10  = 8'h05;
   localparam logic [7:0] RUN_MAX     = 8'hff;
   localparam logic [1:0] RLV_EXTRA   = 2'h1;
   localparam logic [3:0] ONES_MIN    = 4'h4;
   localparam logic [3:0] ONES_MAX    = 4'h6;

   // =====================================================================
   // modes and states
   typedef enum logic [1:0] {
      MODE_MANUAL = 2'b00,
      MODE_SLIP   = 2'b01,
      MODE_AUTO   = 2'b10
   } rwa_mode_t;

   typedef enum logic [1:0] {
      ST_LOSS = 2'b00,
      ST_ACQ  = 2'b01,
      ST_SYNC = 2'b10
   } rwa_sync_t;

endpackage

// ===== src/rwa_rlv.sv
// run-length violation checker of the receive word aligner
`timescale 1ns/10ps
module rwa_rlv
   import rwa_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       dig_reset,
   input  wire logic [9:0] word,
   input  wire logic       w10,
   input  wire logic [4:0] thr_idx,
   output logic            rlv
);

   logic [7:0] run;
   logic       last;
   logic [1:0] hold;
   logic [7:0] next_run;
   logic       next_last;
   logic       hit;
   logic [7:0] thr;

   // =====================================================================
   // serial run count, oldest bit first
   always_comb begin
      // R21: threshold in steps
      thr       = 8'(({3'h0, thr_idx} + 8'h01) * (w10 ? RLV_STEP10 : RLV_STEP8));
      next_run  = run;
      next_last = last;
      hit       = 1'b0;
      // R19: count identical bits
      for (int i = 0; i < W_MAX; i++) begin
         if (w10 || (i < W_MIN)) begin
            if (word[i] == next_last) begin
               if (next_run != RUN_MAX) begin
                  next_run = next_run + 8'h01;
               end
            end else begin
               next_run  = 8'h01;
               next_last = word[i];
            end
            if (next_run >= thr) begin
               hit = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run  <= 8'h00;
         last <= 1'b0;
      end else if (dig_reset) begin
         run  <= 8'h00;
         last <= 1'b0;
      end else begin
         run  <= next_run;
         last <= next_last;
      end
   end

   // R20: stretch to two cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rlv  <= 1'b0;
         hold <= 2'h0;
      end else if (dig_reset) begin
         rlv  <= 1'b0;
         hold <= 2'h0;
      end else if (hit) begin
         rlv  <= 1'b1;
         hold <= RLV_EXTRA;
      end else begin
         rlv  <= (hold != 2'h0);
         hold <= (hold != 2'h0) ? 2'(hold - 2'h1) : 2'h0;
      end
   end

   a_rlv_min_width: // R20
      assert property (@(posedge pclk) disable iff (!presetn || dig_reset)
         $rose(rlv) |=> rlv)
      else $error("run-length flag shorter than two cycles");

endmodule // rwa_rlv

// ===== src/rwa_top.sv
// receive word aligner: apb registers, alignment modes, sync state machine
`timescale 1ns/10ps

// Operation
// R1: find pattern, restore word boundary
// R2: three modes, widths and pattern lengths
// R3: 8-bit manual: rising enable starts search
// R4: 8-bit manual: realign only after new edge
// R5: 10-bit manual: search while enable high
// R6: 10-bit manual: enable low keeps boundary
// R7: boundary update pulses sync and pattern
// R8: status pulses share data path latency
// R9: same boundary pattern pulses pattern only
// R10: user drops enable once aligned
// R11: slip rising edge moves boundary one bit
// R12: slipped data matching pulses pattern seen
// R13: user slip controller drives slip requests
// R14: automatic mode uses 10-bit words only
// R15: acquire and lose counts programmable
// R16: good run lowers error count
// R17: automatic: sync after enough code groups
// R18: sync drops after enough error groups
// R19: count identical bits, flag at threshold
// R20: violation flag lasts two cycles minimum
// R21: threshold steps of four or five
// R22: lowest bit received first
// R23: digital reset clears alignment state
module rwa_top
   import rwa_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [9:0]  rx_data_in,
   input  wire logic        dig_reset,
   input  wire logic        search_en,
   input  wire logic        slip_req,
   output logic      [9:0]  rx_data_out,
   output logic             sync_status,
   output logic             pattern_seen,
   output logic             rlv
);

   // =====================================================================
   // declarations
   logic [1:0]  ctrl_mode;
   logic        ctrl_w10;
   logic        ctrl_p7;
   logic [15:0] pattern;
   logic [7:0]  acq_cfg;
   logic [5:0]  lose_cfg;
   logic [7:0]  good_cfg;
   logic [4:0]  rlv_idx;
   logic        access;
   logic        wr_go;
   logic [31:0] rd_data;
   logic [9:0]  p1;
   logic [9:0]  p2;
   logic [29:0] stream;
   logic        eff_w10;
   logic [3:0]  wlast;
   logic [9:0]  m10;
   logic [9:0]  m8;
   logic [9:0]  match;
   logic        any;
   logic [3:0]  pos;
   logic        at_b;
   logic [3:0]  bnd;
   logic [3:0]  next_bnd;
   logic        upd;
   logic        det;
   logic        det_q;
   logic        syn_q;
   logic        armed;
   logic        se_q;
   logic        sl_q;
   logic        se_rise;
   logic        sl_rise;
   logic [9:0]  grp;
   logic        grp_ok;
   rwa_sync_t   st;
   logic [8:0]  acq_cnt;
   logic [6:0]  err_cnt;
   logic [8:0]  good_cnt;
   logic [8:0]  acq_lim;
   logic [6:0]  lose_lim;
   logic [8:0]  good_lim;

   // =====================================================================
   // functions
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == OFF_CTRL) || (a == OFF_PATTERN) || (a == OFF_SYNC_CFG) ||
                (a == OFF_RLV_CFG) || (a == OFF_STATUS);
   endfunction

   function automatic logic pat_cmp(input logic [9:0] w, input logic [9:0] p,
                                    input logic p7, input logic inv_ok);
      logic [9:0] mask;
      mask    = p7 ? 10'h07f : 10'h3ff;
      pat_cmp = ((w & mask) == (p & mask)) || (inv_ok && ((~w & mask) == (p & mask)));
   endfunction

   function automatic logic [3:0] first_pos(input logic [9:0] v);
      first_pos = 4'h0;
      for (int i = W_MAX - 1; i >= 0; i--) begin
         if (v[i]) begin
            first_pos = 4'(i);
         end
      end
   endfunction

   function automatic logic ones_ok(input logic [9:0] g);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < W_MAX; i++) begin
         n = n + {3'h0, g[i]};
      end
      ones_ok = (n >= ONES_MIN) && (n <= ONES_MAX);
   endfunction

   // =====================================================================
   // apb slave, one wait state
   assign access = psel & penable & ~pready;
   assign wr_go  = psel & penable & pready & pwrite & addr_ok(paddr);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= access;
         pslverr <= access & ~addr_ok(paddr);
         if (access) begin
            prdata <= rd_data;
         end
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      case (paddr)
         OFF_CTRL: begin
            rd_data[CTRL_MODE_LSB +: 2] = ctrl_mode;
            rd_data[CTRL_W10_BIT]       = ctrl_w10;
            rd_data[CTRL_P7_BIT]        = ctrl_p7;
         end
         OFF_PATTERN: rd_data[15:0] = pattern;
         OFF_SYNC_CFG: begin
            rd_data[SYNC_ACQ_LSB +: 8]  = acq_cfg;
            rd_data[SYNC_LOSE_LSB +: 6] = lose_cfg;
            rd_data[SYNC_GOOD_LSB +: 8] = good_cfg;
         end
         OFF_RLV_CFG: rd_data[RLV_IDX_LSB +: 5] = rlv_idx;
         OFF_STATUS: begin
            rd_data[ST_SYNC_BIT]      = sync_status;
            rd_data[ST_RLV_BIT]       = rlv;
            rd_data[ST_BND_LSB +: 4]  = bnd;
            rd_data[ST_STATE_LSB +: 2] = st;
            rd_data[ST_ERR_LSB +: 7]  = err_cnt;
         end
         default: rd_data = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_mode <= MODE_RST;
         ctrl_w10  <= W10_RST;
         ctrl_p7   <= P7_RST;
         pattern   <= PATTERN_RST;
         acq_cfg   <= ACQ_RST;
         lose_cfg  <= LOSE_RST;
         good_cfg  <= GOOD_RST;
         rlv_idx   <= RLV_IDX_RST;
      end else if (wr_go) begin
         case (paddr)
            OFF_CTRL: begin
               ctrl_mode <= pwdata[CTRL_MODE_LSB +: 2];
               ctrl_w10  <= pwdata[CTRL_W10_BIT];
               ctrl_p7   <= pwdata[CTRL_P7_BIT];
            end
            OFF_PATTERN: pattern <= pwdata[15:0];
            OFF_SYNC_CFG: begin
               acq_cfg  <= pwdata[SYNC_ACQ_LSB +: 8];
               lose_cfg <= pwdata[SYNC_LOSE_LSB +: 6];
               good_cfg <= pwdata[SYNC_GOOD_LSB +: 8];
            end
            OFF_RLV_CFG: rlv_idx <= pwdata[RLV_IDX_LSB +: 5];
            default: ;
         endcase
      end
   end

   // =====================================================================
   // stream window and pattern search
   // R14: automatic mode forces 10-bit
   assign eff_w10 = ctrl_w10 | (ctrl_mode == MODE_AUTO);
   assign wlast   = eff_w10 ? BND_LAST10 : BND_LAST8;
   // R22: older words in lower bits
   assign stream  = eff_w10 ? {rx_data_in, p1, p2} :
                              {6'h00, rx_data_in[7:0], p1[7:0], p2[7:0]};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p1 <= 10'h000;
         p2 <= 10'h000;
      end else begin
         p1 <= rx_data_in;
         p2 <= p1;
      end
   end

   // R2: pattern lengths per width
   for (genvar s = 0; s < W_MAX; s++) begin : g_pos
      assign m10[s] = pat_cmp(stream[s + W_MAX +: W_MAX], pattern[9:0], ctrl_p7,
                              ctrl_mode != MODE_SLIP);
      if (s < W_MIN) begin : g_m8
         assign m8[s] = (stream[s +: PAT8_LEN] == pattern);
      end else begin : g_no8
         assign m8[s] = 1'b0;
      end
   end

   // R1: search all bit positions
   assign match = eff_w10 ? m10 : m8;
   assign any   = |match;
   assign pos   = first_pos(match);
   assign at_b  = match[bnd];

   // =====================================================================
   // boundary control
   assign se_rise = search_en & ~se_q;
   assign sl_rise = slip_req & ~sl_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         se_q <= 1'b0;
         sl_q <= 1'b0;
      end else begin
         se_q <= search_en;
         sl_q <= slip_req;
      end
   end

   // R3: arm on enable edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed <= 1'b0;
      end else if (dig_reset) begin
         armed <= 1'b0;
      end else if (se_rise) begin
         armed <= 1'b1;
      end else if (armed && any) begin
         // R4: one alignment per edge
         armed <= 1'b0;
      end
   end

   always_comb begin
      next_bnd = bnd;
      upd      = 1'b0;
      det      = 1'b0;
      unique case (ctrl_mode)
         MODE_SLIP: begin
            // R11: one bit per slip edge
            if (sl_rise) begin
               next_bnd = (bnd == wlast) ? 4'h0 : 4'(bnd + 4'h1);
            end
            // R12: slipped data matches
            det = at_b;
         end
         MODE_AUTO: begin
            // R17: realign while out of sync
            if ((st != ST_SYNC) && any && !at_b) begin
               next_bnd = pos;
               upd      = 1'b1;
            end
            det = upd | at_b;
         end
         default: begin
            // R5: level search in 10-bit, edge armed in 8-bit
            if ((eff_w10 ? search_en : armed) && any && !at_b) begin
               next_bnd = pos;
               upd      = 1'b1;
            end
            // R9: pattern at current boundary
            det = upd | at_b;
         end
      endcase
   end

   // R23: digital reset clears alignment
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bnd <= 4'h0;
      end else if (dig_reset) begin
         bnd <= 4'h0;
      end else begin
         bnd <= next_bnd;
      end
   end

   // =====================================================================
   // synchronization state machine
   assign acq_lim  = {1'b0, acq_cfg} + 9'h001;
   assign lose_lim = {1'b0, lose_cfg} + 7'h01;
   assign good_lim = {1'b0, good_cfg} + 9'h001;
   assign grp      = stream[int'(bnd) + W_MAX +: W_MAX];
   assign grp_ok   = ones_ok(grp);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st       <= ST_LOSS;
         acq_cnt  <= 9'h000;
         err_cnt  <= 7'h00;
         good_cnt <= 9'h000;
      end else if (dig_reset || (ctrl_mode != MODE_AUTO)) begin
         st       <= ST_LOSS;
         acq_cnt  <= 9'h000;
         err_cnt  <= 7'h00;
         good_cnt <= 9'h000;
      end else begin
         unique case (st)
            ST_LOSS: begin
               if (det) begin
                  acq_cnt <= 9'h001;
                  st      <= (acq_lim == 9'h001) ? ST_SYNC : ST_ACQ;
               end
            end
            ST_ACQ: begin
               // R15: acquire count
               if (upd) begin
                  acq_cnt <= 9'h001;
               end else if (at_b) begin
                  acq_cnt <= acq_cnt + 9'h001;
                  if (9'(acq_cnt + 9'h001) == acq_lim) begin
                     st <= ST_SYNC;
                  end
               end else if (!grp_ok) begin
                  acq_cnt <= 9'h000;
                  st      <= ST_LOSS;
               end
            end
            ST_SYNC: begin
               if (!grp_ok) begin
                  // R18: lose after error run
                  good_cnt <= 9'h000;
                  err_cnt  <= err_cnt + 7'h01;
                  if (7'(err_cnt + 7'h01) == lose_lim) begin
                     st      <= ST_LOSS;
                     err_cnt <= 7'h00;
                     acq_cnt <= 9'h000;
                  end
               end else if (9'(good_cnt + 9'h001) == good_lim) begin
                  // R16: good run lowers errors
                  good_cnt <= 9'h000;
                  if (err_cnt != 7'h00) begin
                     err_cnt <= err_cnt - 7'h01;
                  end
               end else begin
                  good_cnt <= good_cnt + 9'h001;
               end
            end
         endcase
      end
   end

   // =====================================================================
   // output pipeline
   // R8: status follows the data word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         det_q        <= 1'b0;
         syn_q        <= 1'b0;
         pattern_seen <= 1'b0;
         sync_status  <= 1'b0;
         rx_data_out  <= 10'h000;
      end else begin
         rx_data_out <= eff_w10 ? stream[int'(bnd) +: W_MAX] :
                                  {2'h0, stream[int'(bnd) +: W_MIN]};
         if (dig_reset) begin
            det_q        <= 1'b0;
            syn_q        <= 1'b0;
            pattern_seen <= 1'b0;
            sync_status  <= 1'b0;
         end else begin
            // R7: update pulses sync too
            det_q        <= det;
            syn_q        <= (ctrl_mode == MODE_AUTO) ? (st == ST_SYNC) :
                            ((ctrl_mode != MODE_SLIP) && upd);
            pattern_seen <= det_q;
            sync_status  <= syn_q;
         end
      end
   end

   rwa_rlv u_rlv (
      .pclk      (pclk),
      .presetn   (presetn),
      .dig_reset (dig_reset),
      .word      (rx_data_in),
      .w10       (eff_w10),
      .thr_idx   (rlv_idx),
      .rlv       (rlv)
   );

   // =====================================================================
   // checks
   a_sync_pairs_pat: // R7
      assert property (@(posedge pclk) disable iff (!presetn)
         (ctrl_mode == MODE_MANUAL) && ($past(ctrl_mode, 2) == MODE_MANUAL) && sync_status
         |-> pattern_seen)
      else $error("manual sync pulse without pattern pulse");

   a_pat_latency: // R8
      assert property (@(posedge pclk) disable iff (!presetn)
         det && !dig_reset ##1 !dig_reset |=> pattern_seen)
      else $error("pattern pulse not two cycles after detection");

   a_same_bound: // R9
      assert property (@(posedge pclk) disable iff (!presetn)
         ($past(ctrl_mode, 2) == MODE_MANUAL) && pattern_seen && !sync_status
         |-> $past(bnd, 2) == $past(bnd, 1))
      else $error("pattern-only pulse but boundary moved");

   a_slip_step: // R11
      assert property (@(posedge pclk) disable iff (!presetn)
         (ctrl_mode == MODE_SLIP) && sl_rise && !dig_reset
         |=> bnd == (($past(bnd) == $past(wlast)) ? 4'h0 : 4'($past(bnd) + 4'h1)))
      else $error("slip did not move boundary one bit");

   a_hold_bound: // R6
      assert property (@(posedge pclk) disable iff (!presetn)
         (ctrl_mode == MODE_MANUAL) && eff_w10 && !search_en && !dig_reset
         |=> $stable(bnd))
      else $error("boundary moved with search disabled");

   a_arm_once: // R4
      assert property (@(posedge pclk) disable iff (!presetn)
         (ctrl_mode == MODE_MANUAL) && !eff_w10 && !armed && !dig_reset
         |=> $stable(bnd))
      else $error("8-bit realign without enable edge");

   a_acq_reach: // R17
      assert property (@(posedge pclk) disable iff (!presetn)
         $rose(st == ST_SYNC) |-> ($past(acq_cnt) == 9'(acq_lim - 9'h001)))
      else $error("sync acquired at wrong group count");

   a_lose_reach: // R18
      assert property (@(posedge pclk) disable iff (!presetn)
         $fell(st == ST_SYNC) && !$past(dig_reset) && ($past(ctrl_mode) == MODE_AUTO)
         |-> ($past(err_cnt) == 7'(lose_lim - 7'h01)))
      else $error("sync lost at wrong error count");

   a_dig_clear: // R23
      assert property (@(posedge pclk) disable iff (!presetn)
         dig_reset |=> !pattern_seen && !sync_status && (bnd == 4'h0) && (err_cnt == 7'h00))
      else $error("digital reset left aligner state");

endmodule // rwa_top

// ===== bench/rwa_partner.sv
// fabric-side model: word source, enable and slip control
`timescale 1ns/10ps
module rwa_partner (
   input  wire logic       pclk,
   input  wire logic [9:0] pat,
   input  wire logic [3:0] k,
   input  wire logic       zeros,
   input  wire logic       want,
   input  wire logic       slip_on,
   input  wire logic       seen,
   output logic      [9:0] word,
   output logic            search_en,
   output logic            slip_req,
   output int              slips
);
   logic [19:0] rot;
   logic        done;
   int          gap;
   assign rot = {pat, pat} >> k;
   initial begin
      {word, search_en, slip_req, done} = '0;
      slips = 0;
      gap = 0;
   end
   // ======================
   // stream and control
   // lowest bit first
   always @(posedge pclk) word <= zeros ? 10'h000 : rot[9:0];
   always @(posedge pclk) begin
      done <= want & (done | seen);
      search_en <= want & ~done & ~seen;
   end
   always @(posedge pclk) begin
      gap <= gap + 1;
      slip_req <= 1'h0;
      if (!slip_on) begin
         gap <= 0;
         slips <= 0;
      end else if (seen) gap <= -1000;
      else if (gap >= 5) begin
         slip_req <= 1'h1;
         slips <= slips + 1;
         gap <= 0;
      end
   end
endmodule // rwa_partner

// ===== bench/tb_top.sv
// self-checking testbench of the receive word aligner
`timescale 1ns/10ps
module tb_top import rwa_pkg::*;;
   logic        pclk, presetn, psel, penable, pwrite, dig_reset, want, slip_on, zeros;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rq;
   logic [9:0]  rx_data_in, rx_data_out;
   logic [3:0]  k;
   logic        pready, pslverr, search_en, slip_req, sync_status, pattern_seen, rlv, re;
   int          fail_count, checked, seed, ns, np, nr, run, minrun, slips, kk, b, s0, p0;
   rwa_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_data_in(rx_data_in), .dig_reset(dig_reset),
      .search_en(search_en), .slip_req(slip_req), .rx_data_out(rx_data_out),
      .sync_status(sync_status), .pattern_seen(pattern_seen), .rlv(rlv));
   rwa_partner far (.pclk(pclk), .pat(PATTERN_RST[9:0]), .k(k), .zeros(zeros),
      .want(want), .slip_on(slip_on), .seen(pattern_seen), .word(rx_data_in),
      .search_en(search_en), .slip_req(slip_req), .slips(slips));
   // ======================
   // helpers
   initial begin
      pclk = 0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      ns += sync_status;
      np += pattern_seen;
      nr += rlv;
      if (rlv) run++;
      else begin
         if (run > 0 && run < minrun) minrun = run;
         run = 0;
      end
   end
   function int bnd(input int x);
      return (10 - x) % 10;
   endfunction
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rq = prdata;
      re = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
      if (n >= 20) fail_count++;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task drst;
      dig_reset <= 1'h1;
      @(posedge pclk);
      dig_reset <= 1'h0;
      @(posedge pclk);
   endtask
   task test_done;
      if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #20000;
      fail_count++;
      test_done;
   end
   // ======================
   // scenarios
   initial begin
      {psel, penable, pwrite, dig_reset, want, slip_on, zeros} = '0;
      {paddr, pwdata, k, presetn} = '0;
      {seed, fail_count, checked, ns, np, nr, run} = '0;
      seed = 79;
      minrun = 99;
      cyc(3);
      presetn <= 1'h1;
      cyc(1);
      apb(0, OFF_PATTERN, 0); chk("pattern", {16'h0, PATTERN_RST}, rq);
      apb(0, 8'h40, 0); chk("slverr", 1, re);
      kk = ($random(seed) & 32'h7fff) % 9 + 1;
      k <= 4'(kk);
      b = bnd(kk);
      drst;
      want <= 1'h1;
      s0 = ns;
      p0 = np;
      cyc(30);
      chk("sync pulses", 1, ns - s0);
      chk("seen pulses", 1, (np - p0) > 20);
      chk("aligned", PATTERN_RST[9:0], rx_data_out);
      apb(0, OFF_STATUS, 0); chk("boundary", b, rq[5:2]);
      want <= 1'h0;
      kk = (kk + 3) % 10;
      k <= 4'(kk);
      cyc(6);
      s0 = ns;
      p0 = np;
      cyc(20);
      chk("held sync", 0, ns - s0);
      chk("held seen", 0, np - p0);
      apb(0, OFF_STATUS, 0); chk("kept", b, rq[5:2]);
      want <= 1'h1;
      cyc(20);
      chk("realign", PATTERN_RST[9:0], rx_data_out);
      want <= 1'h0;
      apb(1, OFF_CTRL, 32'h5);
      drst;
      slip_on <= 1'h1;
      cyc(90);
      chk("slips", bnd(kk), slips);
      chk("slip data", PATTERN_RST[9:0], rx_data_out);
      slip_on <= 1'h0;
      apb(1, OFF_CTRL, 32'h6);
      drst;
      cyc(30);
      chk("acquired", 1, sync_status);
      drst;
      chk("rst sync", 0, sync_status);
      chk("rst seen", 0, pattern_seen);
      cyc(30);
      zeros <= 1'h1;
      cyc(25);
      chk("lost", 0, sync_status);
      chk("long run", 1, nr > 0);
      zeros <= 1'h0;
      apb(1, OFF_RLV_CFG, 1);
      cyc(5);
      s0 = nr;
      cyc(20);
      chk("below thr", 0, nr - s0);
      apb(1, OFF_RLV_CFG, 0);
      cyc(5);
      s0 = nr;
      cyc(20);
      chk("at thr", 1, nr - s0 > 0);
      chk("rlv width", 1, minrun >= 2);
      test_done;
   end
endmodule // tb_top
